// File: hdl/trd_detect.sv
// Purpose: reference keeping, touch/snap/proximity detection, APB register slave
// Assumes: counts arrive from same-clock sensing engines, one sample per cycle
// Notes: channel bitmaps limit NCH to 32
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module trd_detect
    import trd_pkg::*;
#(
    parameter int NCH = 32,
    parameter int NENG = 13,
    parameter int SEC_CNT = SEC_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] sys_mode,
    input wire logic cyc_start,
    input wire logic cyc_done,
    input wire logic tp_cnt_valid,
    input wire logic [$clog2(NCH)-1:0] tp_cnt_idx,
    input wire logic [15:0] tp_cnt_val,
    input wire logic alp_cnt_valid,
    input wire logic [15:0] alp_cnt_val,
    input wire logic ap_cnt_valid,
    input wire logic [3:0] ap_cnt_idx,
    input wire logic [15:0] ap_cnt_val,
    output logic [NCH-1:0] touch_status,
    output logic [NCH-1:0] snap_status,
    output logic proximity_detect_flag,
    output logic prox_wake
);
    localparam int IW = $clog2(NCH);

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic [8:0] eff_mult(input logic [7:0] g, input logic [7:0] a);
        logic signed [9:0] s;
        s = $signed({2'b00, g}) + $signed({{2{a[7]}}, a});
        if (s < 0)
        begin
            eff_mult = 9'(MULT_BASE);
        end
        else
        begin
            eff_mult = 9'(MULT_BASE) + s[8:0];
        end
    endfunction : eff_mult

    function automatic logic [15:0] filt_step(input logic [15:0] f, input logic [15:0] x,
                                              input logic [7:0] beta);
        logic [10:0] k;
        logic signed [16:0] d;
        logic signed [28:0] p;
        logic signed [17:0] r;
        k = (beta == 8'h00) ? 11'h001 : ({beta, 3'b000} - 11'h007);
        d = $signed({1'b0, x}) - $signed({1'b0, f});
        p = d * $signed({1'b0, k});
        r = $signed({2'b00, f}) + $signed(p[28:DAMP_SHIFT]);
        filt_step = r[15:0];
    endfunction : filt_step

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    // ***********************************
    // register state
    // ***********************************
    logic [4:0] ctrl_r, ctrl_nxt;
    logic snap_tog_r, snap_tog_nxt;
    logic wake_r, wake_nxt;
    logic [15:0] tmult_r, tmult_nxt;
    logic [15:0] snapt_r, snapt_nxt;
    logic [15:0] times_r, times_nxt;
    logic [23:0] beta_r, beta_nxt;
    logic [31:0] athr_r, athr_nxt;
    logic [15:0] adeb_r, adeb_nxt;
    logic [IW-1:0] chsel_r, chsel_nxt;
    logic [NCH-1:0] snap_en_r, snap_en_nxt;
    logic [7:0] adj_mem [NCH];
    logic adj_we;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    // channel state
    logic [15:0] ref_mem [NCH];
    logic [15:0] cnt_mem [NCH];
    logic [NCH-1:0] touch_r, touch_nxt;
    logic [NCH-1:0] snap_r, snap_nxt;
    logic ref_we;
    logic [15:0] ref_wval;
    logic snap_chg;
    logic tp_arm_r, tp_arm_nxt;
    // proximity channel state
    logic [15:0] filt_r, filt_nxt;
    logic [15:0] lta_r, lta_nxt;
    logic [7:0] deb_r, deb_nxt;
    logic prox_r, prox_nxt;
    logic alp_done;
    logic [15:0] ap_base [NENG];
    logic [NENG-1:0] ap_ok_r, ap_ok_nxt;
    logic ap_we;
    logic ap_wake;
    // timers
    logic [31:0] sec_cnt_r, sec_cnt_nxt;
    logic tick_r, tick_nxt;
    logic [7:0] ref_sec_r, ref_sec_nxt;
    logic ref_pend_r, ref_pend_nxt;
    logic [7:0] snp_sec_r, snp_sec_nxt;
    logic snp_pend_r, snp_pend_nxt;

    logic acc_ok, wr_en, rd_en, in_lp, quiet, tp_done;
    assign acc_ok = psel & penable & pready_r;
    assign wr_en = acc_ok & pwrite;
    assign in_lp = (sys_mode == TRD_LP1) | (sys_mode == TRD_LP2);
    assign quiet = ~(|touch_r) & ~(|snap_r);
    assign rd_en = psel & penable & ~pready_r & ~pwrite;
    assign tp_done = tp_arm_r & cyc_done;

    // ***********************************
    // apb slave and registers
    // ***********************************
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        snap_tog_nxt = snap_tog_r;
        wake_nxt = wake_r;
        tmult_nxt = tmult_r;
        snapt_nxt = snapt_r;
        times_nxt = times_r;
        beta_nxt = beta_r;
        athr_nxt = athr_r;
        adeb_nxt = adeb_r;
        chsel_nxt = chsel_r;
        snap_en_nxt = snap_en_r;
        adj_we = 1'b0;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        // one wait state: answer registered in the first access cycle
        pready_nxt = psel & penable & ~pready_r;
        // completion clears the reseed bits; a write below may set them again
        if (tp_done)
            ctrl_nxt[CTRL_TRACKPAD_RESEED_BIT] = 1'b0;
        if (alp_done)
            ctrl_nxt[CTRL_PROX_CHANNEL_RESEED_BIT] = 1'b0;
        if (wr_en)
        begin
            case (paddr)
                OFF_CTRL: ctrl_nxt = pwdata[4:0];
                OFF_INFO:
                begin
                    if (pwdata[INFO_SNAP_TOG])
                        snap_tog_nxt = 1'b0;
                    if (pwdata[INFO_WAKE])
                        wake_nxt = 1'b0;
                end
                OFF_TMULT: tmult_nxt = pwdata[15:0];
                OFF_SNAPT: snapt_nxt = pwdata[15:0];
                OFF_TIMES: times_nxt = pwdata[15:0];
                OFF_BETA: beta_nxt = pwdata[23:0];
                OFF_ATHR: athr_nxt = pwdata;
                OFF_ADEB: adeb_nxt = pwdata[15:0];
                OFF_CHSEL: chsel_nxt = pwdata[IW-1:0];
                OFF_CHCFG:
                begin
                    adj_we = 1'b1;
                    snap_en_nxt[chsel_r] = pwdata[CHCFG_SNAP_EN];
                end
                default: ;
            endcase
        end
        // hardware events win over a same-cycle clear
        if (snap_chg)
            snap_tog_nxt = 1'b1;
        if (ap_wake)
            wake_nxt = 1'b1;
        if (psel & penable & ~pready_r)
        begin
            prdata_nxt = 32'h0000_0000;
            pslverr_nxt = 1'b0;
            case (paddr)
                OFF_CTRL: prdata_nxt = {27'h000_0000, ctrl_r};
                OFF_INFO: prdata_nxt = {28'h000_0000, |touch_r, wake_r, snap_tog_r, prox_r};
                OFF_TMULT: prdata_nxt = {16'h0000, tmult_r};
                OFF_SNAPT: prdata_nxt = {16'h0000, snapt_r};
                OFF_TIMES: prdata_nxt = {16'h0000, times_r};
                OFF_BETA: prdata_nxt = {8'h00, beta_r};
                OFF_ATHR: prdata_nxt = athr_r;
                OFF_ADEB: prdata_nxt = {16'h0000, adeb_r};
                OFF_LTA: prdata_nxt = {filt_r, lta_r};
                OFF_CHSEL: prdata_nxt = 32'(chsel_r);
                OFF_CHCFG: prdata_nxt = {23'h00_0000, snap_en_r[chsel_r], adj_mem[chsel_r]};
                OFF_CHSTAT: prdata_nxt = {cnt_mem[chsel_r] - ref_mem[chsel_r], ref_mem[chsel_r]};
                OFF_TBITS: prdata_nxt = 32'(touch_r);
                OFF_SBITS: prdata_nxt = 32'(snap_r);
                default: pslverr_nxt = 1'b1;
            endcase
            if (~rd_en && paddr > OFF_SBITS)
                pslverr_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= RST_CTRL;
            snap_tog_r <= 1'b0;
            wake_r <= 1'b0;
            tmult_r <= RST_TMULT;
            snapt_r <= RST_SNAPT;
            times_r <= RST_TIMES;
            beta_r <= RST_BETA;
            athr_r <= RST_ATHR;
            adeb_r <= RST_ADEB;
            chsel_r <= '0;
            snap_en_r <= '0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            snap_tog_r <= snap_tog_nxt;
            wake_r <= wake_nxt;
            tmult_r <= tmult_nxt;
            snapt_r <= snapt_nxt;
            times_r <= times_nxt;
            beta_r <= beta_nxt;
            athr_r <= athr_nxt;
            adeb_r <= adeb_nxt;
            chsel_r <= chsel_nxt;
            snap_en_r <= snap_en_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // adjustment memory has no reset; software loads it before use
    always_ff @(posedge pclk)
    begin
        if (adj_we)
            adj_mem[chsel_r] <= pwdata[7:0];
    end

    // ***********************************
    // trackpad channels
    // ***********************************
    logic [15:0] cur_ref;
    logic [25:0] lhs, rhs_set, rhs_clr;
    logic [16:0] snap_set_sum, snap_clr_sum;
    logic tch_bit, snp_bit;
    always_comb
    begin
        touch_nxt = touch_r;
        snap_nxt = snap_r;
        ref_we = 1'b0;
        ref_wval = tp_cnt_val;
        snap_chg = 1'b0;
        tp_arm_nxt = tp_arm_r;
        cur_ref = ref_mem[tp_cnt_idx];
        lhs = {3'b000, tp_cnt_val, 7'b000_0000};
        rhs_set = 26'(cur_ref) * 26'(eff_mult(tmult_r[7:0], adj_mem[tp_cnt_idx]));
        rhs_clr = 26'(cur_ref) * 26'(eff_mult(tmult_r[15:8], adj_mem[tp_cnt_idx]));
        snap_set_sum = {1'b0, tp_cnt_val} + {9'h000, snapt_r[7:0]};
        snap_clr_sum = {1'b0, tp_cnt_val} + {9'h000, snapt_r[15:8]};
        tch_bit = touch_r[tp_cnt_idx] ? (lhs > rhs_clr) : (lhs > rhs_set);
        snp_bit = snap_en_r[tp_cnt_idx] & (snap_r[tp_cnt_idx] ?
                  (snap_clr_sum < {1'b0, cur_ref}) : (snap_set_sum < {1'b0, cur_ref}));
        // a reseed or refresh covers one whole sensing cycle
        if (cyc_start & ~tp_arm_r)
        begin
            tp_arm_nxt = ctrl_r[CTRL_TRACKPAD_RESEED_BIT] | snp_pend_r
                       | (ref_pend_r & ~ctrl_r[CTRL_MANUAL] & in_lp & quiet);
        end
        if (tp_done)
            tp_arm_nxt = 1'b0;
        if (tp_cnt_valid)
        begin
            touch_nxt[tp_cnt_idx] = tch_bit;
            snap_nxt[tp_cnt_idx] = snp_bit;
            snap_chg = snap_en_r[tp_cnt_idx] & (snp_bit != snap_r[tp_cnt_idx]);
            ref_we = tp_arm_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            touch_r <= '0;
            snap_r <= '0;
            tp_arm_r <= 1'b0;
        end
        else
        begin
            touch_r <= touch_nxt;
            snap_r <= snap_nxt;
            tp_arm_r <= tp_arm_nxt;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (tp_cnt_valid)
            cnt_mem[tp_cnt_idx] <= tp_cnt_val;
        if (ref_we)
            ref_mem[tp_cnt_idx] <= ref_wval;
    end

    // ***********************************
    // proximity channel and auto-prox
    // ***********************************
    logic [15:0] lta_beta, dev, ap_dev;
    logic det;
    always_comb
    begin
        filt_nxt = filt_r;
        lta_nxt = lta_r;
        deb_nxt = deb_r;
        prox_nxt = prox_r;
        alp_done = 1'b0;
        lta_beta = 16'h0000;
        dev = 16'h0000;
        det = 1'b0;
        if (alp_cnt_valid)
        begin
            filt_nxt = ctrl_r[CTRL_FILT_EN] ? filt_step(filt_r, alp_cnt_val, beta_r[23:16]) : alp_cnt_val;
            lta_beta = (sys_mode == TRD_LP2) ? {8'h00, beta_r[15:8]} : {8'h00, beta_r[7:0]};
            if (ctrl_r[CTRL_PROX_CHANNEL_RESEED_BIT])
            begin
                lta_nxt = filt_nxt;
                alp_done = 1'b1;
            end
            else if (~prox_r & in_lp)
                lta_nxt = filt_step(lta_r, filt_nxt, lta_beta[7:0]);
            dev = abs_diff(filt_nxt, lta_r);
            det = dev > athr_r[15:0];
            // debounce: state flips on the disagreeing sample after the count reaches the threshold
            if (det == prox_r)
                deb_nxt = 8'h00;
            else if (deb_r >= (prox_r ? adeb_r[15:8] : adeb_r[7:0]))
            begin
                prox_nxt = det;
                deb_nxt = 8'h00;
            end
            else
                deb_nxt = deb_r + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt_r <= 16'h0000;
            lta_r <= 16'h0000;
            deb_r <= 8'h00;
            prox_r <= 1'b0;
        end
        else
        begin
            filt_r <= filt_nxt;
            lta_r <= lta_nxt;
            deb_r <= deb_nxt;
            prox_r <= prox_nxt;
        end
    end

    // engine baselines follow the raw count only while it stays inside the band, or on an engine's first sample after reset or reseed
    always_comb
    begin
        ap_ok_nxt = ap_ok_r;
        ap_we = 1'b0;
        ap_wake = 1'b0;
        ap_dev = abs_diff(ap_cnt_val, ap_base[ap_cnt_idx]);
        if (ap_cnt_valid && ctrl_r[CTRL_AP_EN] && 32'(ap_cnt_idx) < NENG)
        begin
            ap_ok_nxt[ap_cnt_idx] = 1'b1;
            if (ap_ok_r[ap_cnt_idx] && ap_dev > athr_r[31:16])
                ap_wake = 1'b1;
            else
                ap_we = 1'b1;
        end
        if (ctrl_r[CTRL_PROX_CHANNEL_RESEED_BIT])
            ap_ok_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ap_ok_r <= '0;
        else
            ap_ok_r <= ap_ok_nxt;
    end

    always_ff @(posedge pclk)
    begin
        if (ap_we)
            ap_base[ap_cnt_idx] <= ap_cnt_val;
    end

    // ***********************************
    // second timers
    // ***********************************
    logic [7:0] ref_ivl;
    always_comb
    begin
        sec_cnt_nxt = sec_cnt_r + 32'h0000_0001;
        tick_nxt = 1'b0;
        if (sec_cnt_r >= 32'(SEC_CNT - 1))
        begin
            sec_cnt_nxt = 32'h0000_0000;
            tick_nxt = 1'b1;
        end
        ref_ivl = (times_r[7:0] > REF_MAX_S) ? REF_MAX_S : times_r[7:0];
        ref_sec_nxt = ref_sec_r;
        ref_pend_nxt = ref_pend_r;
        if (tick_r && ref_ivl != 8'h00)
        begin
            if (ref_sec_r + 8'h01 >= ref_ivl)
            begin
                ref_sec_nxt = 8'h00;
                ref_pend_nxt = 1'b1;
            end
            else
                ref_sec_nxt = ref_sec_r + 8'h01;
        end
        snp_sec_nxt = snp_sec_r;
        snp_pend_nxt = snp_pend_r;
        if (snap_chg || !(|snap_r) || times_r[15:8] == 8'h00)
            snp_sec_nxt = 8'h00;
        else if (tick_r)
        begin
            if (snp_sec_r + 8'h01 >= times_r[15:8])
            begin
                snp_sec_nxt = 8'h00;
                snp_pend_nxt = 1'b1;
            end
            else
                snp_sec_nxt = snp_sec_r + 8'h01;
        end
        if (tp_arm_nxt & ~tp_arm_r)
        begin
            ref_pend_nxt = 1'b0;
            snp_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
            ref_sec_r <= 8'h00;
            ref_pend_r <= 1'b0;
            snp_sec_r <= 8'h00;
            snp_pend_r <= 1'b0;
        end
        else
        begin
            sec_cnt_r <= sec_cnt_nxt;
            tick_r <= tick_nxt;
            ref_sec_r <= ref_sec_nxt;
            ref_pend_r <= ref_pend_nxt;
            snp_sec_r <= snp_sec_nxt;
            snp_pend_r <= snp_pend_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign touch_status = touch_r;
    assign snap_status = snap_r;
    assign proximity_detect_flag = prox_r;
    assign prox_wake = wake_r;
endmodule : trd_detect
`default_nettype wire

// File: hdl/trd_pkg.sv
// Purpose: constants for the trackpad reference / threshold detection block
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
package trd_pkg;
    // ***********************************
    // register map
    // ***********************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INFO = 8'h04;
    localparam logic [7:0] OFF_TMULT = 8'h08;
    localparam logic [7:0] OFF_SNAPT = 8'h0C;
    localparam logic [7:0] OFF_TIMES = 8'h10;
    localparam logic [7:0] OFF_BETA = 8'h14;
    localparam logic [7:0] OFF_ATHR = 8'h18;
    localparam logic [7:0] OFF_ADEB = 8'h1C;
    localparam logic [7:0] OFF_LTA = 8'h20;
    localparam logic [7:0] OFF_CHSEL = 8'h24;
    localparam logic [7:0] OFF_CHCFG = 8'h28;
    localparam logic [7:0] OFF_CHSTAT = 8'h2C;
    localparam logic [7:0] OFF_TBITS = 8'h30;
    localparam logic [7:0] OFF_SBITS = 8'h34;
    // ***********************************
    // field positions
    // ***********************************
    localparam int CTRL_TRACKPAD_RESEED_BIT = 0;
    localparam int CTRL_PROX_CHANNEL_RESEED_BIT = 1;
    localparam int CTRL_MANUAL = 2;
    localparam int CTRL_FILT_EN = 3;
    localparam int CTRL_AP_EN = 4;
    localparam int INFO_PROX = 0;
    localparam int INFO_SNAP_TOG = 1;
    localparam int INFO_WAKE = 2;
    localparam int INFO_TOUCH_ANY = 3;
    localparam int CHCFG_SNAP_EN = 8;
    // ***********************************
    // reset values
    // ***********************************
    localparam logic [4:0] RST_CTRL = 5'h18;
    localparam logic [15:0] RST_TMULT = 16'h1014;
    localparam logic [15:0] RST_SNAPT = 16'h3040;
    localparam logic [15:0] RST_TIMES = 16'h0A14;
    localparam logic [23:0] RST_BETA = 24'h02_0406;
    localparam logic [31:0] RST_ATHR = 32'h0014_000A;
    localparam logic [15:0] RST_ADEB = 16'h0202;
    // ***********************************
    // timing
    // ***********************************
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_S = 1;
    localparam int SEC_CYCLES = TICK_S * CLK_HZ;
    localparam logic [7:0] REF_MAX_S = 8'h3C;
    localparam int DAMP_SHIFT = 11;
    localparam int MULT_BASE = 128;
    typedef enum logic [1:0] {
        TRD_ACTIVE = 2'b00,
        TRD_IDLE = 2'b01,
        TRD_LP1 = 2'b10,
        TRD_LP2 = 2'b11
    } trd_mode_t;
endpackage : trd_pkg

// File: testbench/test_trd_detect.sv
// Purpose: self-checking bench for trd_detect
// Assumes: channels 3 and 4, count filter off for prox
// Notes: short second count
`timescale 1ns/1ps
`default_nettype none
module test_trd_detect
    import trd_pkg::*;
;
    // ****************
    // bench
    // ****************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic proximity_detect_flag, prox_wake;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, touch_status, snap_status;
    logic [1:0] sys_mode;
    logic [4:0] strobe, idx;
    logic [15:0] val;
    logic [7:0] ra[7] = '{OFF_CTRL, OFF_TMULT, OFF_SNAPT, OFF_TIMES, OFF_BETA, OFF_ATHR, OFF_ADEB};
    logic [31:0] rv[7] = '{32'(RST_CTRL), 32'(RST_TMULT), 32'(RST_SNAPT), 32'(RST_TIMES),
        32'(RST_BETA), RST_ATHR, 32'(RST_ADEB)};
    logic [15:0] pv[3] = '{16'h01FF, 16'h01F4, 16'h01E9};
    int err_total, comparisons, j;
    trd_detect #(.SEC_CNT(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_mode(sys_mode), .cyc_start(strobe[3]), .cyc_done(strobe[4]),
        .tp_cnt_valid(strobe[0]), .tp_cnt_idx(idx), .tp_cnt_val(val),
        .alp_cnt_valid(strobe[1]), .alp_cnt_val(val), .ap_cnt_valid(strobe[2]),
        .ap_cnt_idx(idx[3:0]), .ap_cnt_val(val), .touch_status(touch_status),
        .snap_status(snap_status), .proximity_detect_flag(proximity_detect_flag),
        .prox_wake(prox_wake)
    );
    trd_engine_model eng_u (.pclk(pclk), .strobe(strobe), .idx(idx), .val(val));
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        comparisons++;
        if (y !== x)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk("prdata", x, q);
    endtask : rd
    task automatic tp(input logic [4:0] i, input logic [15:0] v, input logic t, input logic s);
        eng_u.send(0, i, v);
        #1;
        chk("touch", t, touch_status[i]);
        chk("snap", s, snap_status[i]);
    endtask : tp
    task automatic complete_run();
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        err_total++;
        complete_run();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sys_mode} = '0;
        err_total = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i])
            rd(ra[i], rv[i]);
        bus(1'b0, 8'h38, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, e);
        chk("prdata", 32'h0000_0000, q);
        wr(OFF_CHSEL, 32'h0000_0003);
        wr(OFF_CHCFG, 32'h0000_0000);
        wr(OFF_CHSEL, 32'h0000_0004);
        wr(OFF_CHCFG, 32'h0000_0100);
        wr(OFF_CTRL, 32'h0000_0019);
        eng_u.send(3, 5'h00, 16'h0000);
        // second pass compares against the fresh copy, so status from the unset reference clears
        repeat (2)
        begin
            eng_u.send(0, 5'h03, 16'h03E8);
            eng_u.send(0, 5'h04, 16'h03E8);
        end
        eng_u.send(4, 5'h00, 16'h0000);
        rd(OFF_CTRL, 32'h0000_0018);
        rd(OFF_CHSTAT, 32'h0000_03E8);
        tp(5'h03, 16'h0484, 1'b0, 1'b0);
        tp(5'h03, 16'h0485, 1'b1, 1'b0);
        tp(5'h03, 16'h0466, 1'b1, 1'b0);
        tp(5'h03, 16'h0465, 1'b0, 1'b0);
        wr(OFF_CHSEL, 32'h0000_0003);
        wr(OFF_CHCFG, 32'h0000_00FC);
        tp(5'h03, 16'h0466, 1'b1, 1'b0);
        rd(OFF_CHSTAT, 32'h007E_03E8);
        tp(5'h04, 16'h03A7, 1'b0, 1'b1);
        rd(OFF_INFO, 32'h0000_000A);
        wr(OFF_INFO, 32'h0000_0002);
        tp(5'h04, 16'h03B7, 1'b0, 1'b1);
        rd(OFF_INFO, 32'h0000_0008);
        tp(5'h04, 16'h03B8, 1'b0, 1'b0);
        rd(OFF_INFO, 32'h0000_000A);
        tp(5'h03, 16'h0384, 1'b0, 1'b0);
        // filter off so the filtered count equals the raw one
        wr(OFF_CTRL, 32'h0000_0012);
        eng_u.send(3, 5'h00, 16'h0000);
        eng_u.send(1, 5'h00, 16'h01F4);
        eng_u.send(4, 5'h00, 16'h0000);
        rd(OFF_LTA, 32'h01F4_01F4);
        // the reseed sample still counted against the old average; an agreeing sample drops that count
        eng_u.send(1, 5'h00, 16'h01F4);
        for (j = 0; j < 9; j++)
        begin
            eng_u.send(1, 5'h00, pv[j / 3]);
            #1;
            chk("prox", 32'(((j % 3) == 2) ^ ((j / 3) == 1)), proximity_detect_flag);
        end
        rd(OFF_LTA, 32'h01E9_01F4);
        eng_u.send(2, 5'h00, 16'h012C);
        eng_u.send(2, 5'h0D, 16'h0384);
        #1;
        chk("wake", 32'h0000_0000, prox_wake);
        eng_u.send(2, 5'h00, 16'h0141);
        #1;
        chk("wake", 32'h0000_0001, prox_wake);
        wr(OFF_INFO, 32'h0000_0004);
        #1;
        chk("wake", 32'h0000_0000, prox_wake);
        // low power: average frozen while prox is set, then tracks with the mode's beta
        @(posedge pclk);
        sys_mode <= TRD_LP1;
        eng_u.send(1, 5'h00, 16'h01E9);
        rd(OFF_LTA, 32'h01E9_01F4);
        repeat (3) eng_u.send(1, 5'h00, 16'h01F4);
        eng_u.send(1, 5'h00, 16'h02F4);
        rd(OFF_LTA, 32'h02F4_01F9);
        sys_mode <= TRD_LP2;
        eng_u.send(1, 5'h00, 16'h02F4);
        rd(OFF_LTA, 32'h02F4_01FC);
        complete_run();
    end
endmodule : test_trd_detect
`default_nettype wire

// File: testbench/trd_detect_properties.sv
// Purpose: port checks for trd_detect
// Assumes: one clock, one apb wait state
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module trd_detect_properties
    import trd_pkg::*;
#(
    parameter int NCH = 32
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tp_cnt_valid,
    input wire logic alp_cnt_valid,
    input wire logic ap_cnt_valid,
    input wire logic [NCH-1:0] touch_status,
    input wire logic proximity_detect_flag,
    input wire logic prox_wake
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_one_a: assert property (pready |=> !pready)
        else $error("pready held");
    ready_late_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    bad_addr_a: assert property (psel && penable && !pready |=> pslverr == ($past(paddr) > OFF_SBITS))
        else $error("pslverr wrong");
    bad_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    touch_hold_a: assert property (!tp_cnt_valid |=> $stable(touch_status))
        else $error("touch moved");
    prox_hold_a: assert property (!alp_cnt_valid |=> $stable(proximity_detect_flag))
        else $error("prox moved");
    wake_cause_a: assert property ($rose(prox_wake) |-> $past(ap_cnt_valid))
        else $error("wake no cause");
    wake_keep_a: assert property (prox_wake && !(pready && pwrite) |=> prox_wake)
        else $error("wake lost");
endmodule : trd_detect_properties
bind trd_detect trd_detect_properties #(.NCH(NCH)) prop_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tp_cnt_valid(tp_cnt_valid), .alp_cnt_valid(alp_cnt_valid),
    .ap_cnt_valid(ap_cnt_valid), .touch_status(touch_status),
    .proximity_detect_flag(proximity_detect_flag), .prox_wake(prox_wake)
);
`default_nettype wire

// File: testbench/trd_engine_model.sv
// Purpose: sensing engine stand-in
// Assumes: strobe bits tp, alp, ap, start, done
// Notes: released count shows inverse value
`timescale 1ns/1ps
`default_nettype none
module trd_engine_model (
    input wire logic pclk,
    output logic [4:0] strobe,
    output logic [4:0] idx,
    output logic [15:0] val
);
    // ****************
    // one-cycle sample pulses
    // ****************
    initial
    begin
        strobe = 5'h00;
        idx = 5'h00;
        val = 16'h0000;
    end
    task automatic send(input int k, input logic [4:0] i, input logic [15:0] v);
        @(posedge pclk);
        strobe <= 5'(1 << k);
        idx <= i;
        val <= v;
        @(posedge pclk);
        strobe <= 5'h00;
        // stale count must never look valid
        val <= ~v;
    endtask : send
endmodule : trd_engine_model
`default_nettype wire
